// >>> rtl/rss_pkg.sv
// Constants shared by the reset cause status block
package rss_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0] CAUSE_OFS      = 8'h00;
    localparam logic [7:0] OPTIONS_OFS    = 8'h04;
    localparam logic [7:0] DBG_FORCE_OFS  = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h0c;
    localparam logic [7:0] IRQ_MASK_OFS   = 8'h10;
    localparam logic [7:0] IRQ_SRC_EN_OFS = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // Reset cause register field positions
    localparam int CAUSE_W         = 8;
    localparam int POWER_ON_BIT    = 7;
    localparam int PIN_RESET_BIT   = 6;
    localparam int WATCHDOG_BIT    = 5;
    localparam int ILLEGAL_OP_BIT  = 4;
    localparam int CLOCK_FAULT_BIT = 2;
    localparam int LOW_VOLTAGE_BIT = 1;

    // Reset cause value after power-on
    localparam logic [7:0] CAUSE_POR_VALUE = 8'h82;

    ////////////////////////////////////////////////////////////////////////
    // Options register field positions and reset values
    localparam int           WDOG_EN_BIT   = 0;
    localparam int           STOP_EN_BIT   = 1;
    localparam int           BDM_EN_BIT    = 2;
    localparam logic [2:0]   OPTIONS_RESET = 3'h1;

    // Debug force register field position
    localparam int DBG_FORCE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt layout: bit 0 is the internal reset capture event
    localparam int IRQ_CAPTURE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////
    // Timing: system reset held this many bus cycles
    localparam int         RESET_HOLD_CYCLES = 34;
    localparam int         HOLD_CNT_W        = 6;
    localparam logic [5:0] HOLD_CNT_LAST     = 6'(RESET_HOLD_CYCLES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer states
    typedef enum logic [0:0] {
        RSS_RUN,
        RSS_HOLD
    } rss_state_t;

endpackage

// >>> rtl/rss_reset_status.sv
// Reset cause capture, watchdog restart decode, options and interrupt gating with APB slave
//
// Function
// - Eight-bit reset cause register with six read-only source flags.
// - Debug forced reset leaves every cause flag cleared.
// - Any write to cause address restarts watchdog; data ignored.
// - Power-on sets power-on and low-voltage flags, clears others.
// - Low-voltage reset sets its flag, clears four, keeps power-on flag.
// - Other resets clear power-on, low-voltage; others follow active sources.
// - Pin flag bit 6 set when external low level caused reset.
// - Watchdog flag bit 5 set when watchdog timeout caused reset.
// - Watchdog disabled means no watchdog reset and no watchdog flag.
// - Illegal opcode flag bit 4 set on illegal opcode reset.
// - Stop instruction is illegal while stop enable is zero.
// - Background entry is illegal while background mode enable is zero.
// - Event in an enabled interrupt source sets its status flag.
// - Interrupt output only for flags whose local enable is one.
// - Clock fault flag bit 2 records clock loss or lock loss reset.
`timescale 1ns/100ps

module rss_reset_status
#(
    parameter int IRQ_EXT = 4
)
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [rss_pkg::ADDR_W-1:0] paddr,
    input  wire logic [rss_pkg::DATA_W-1:0] pwdata,
    output logic      [rss_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       pin_reset_n,
    input  wire logic                       low_voltage_det,
    input  wire logic                       watchdog_timeout,
    input  wire logic                       illegal_opcode,
    input  wire logic                       stop_exec,
    input  wire logic                       background_entry_instruction_exec,
    input  wire logic                       clock_fault,
    input  wire logic [IRQ_EXT-1:0]         irq_event,
    output logic                            sys_reset,
    output logic                            wdog_restart,
    output logic                            wdog_enable,
    output logic                            stop_enable,
    output logic                            bdm_enable,
    output logic                            irq
);

    import rss_pkg::*;
    localparam int IRQ_W = IRQ_EXT + 1;

    ////////////////////////////////////////////////////////////////////////
    // Address match helper
    function automatic logic rss_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
        rss_hit = (addr == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [CAUSE_W-1:0]    cause_reg;
    logic [CAUSE_W-1:0]    cause_next;
    logic [2:0]            options_reg;
    logic [IRQ_W-1:0]      irq_status_reg;
    logic [IRQ_W-1:0]      irq_mask_reg;
    logic [IRQ_W-1:0]      irq_src_en_reg;
    logic [IRQ_W-1:0]      irq_raw;
    logic                  dbg_force_reg;
    rss_state_t            state_reg;
    logic [HOLD_CNT_W-1:0] hold_cnt_reg;
    logic [2:0]            pin_sync_reg;
    logic                  pin_low_reg;
    logic [2:0]            lv_sync_reg;
    logic                  lv_reg;
    logic                  wdog_src;
    logic                  illegal_opcode_flag_src;
    logic                  any_src;
    logic                  capture;
    logic                  setup_phase;
    logic                  wr_fire;
    logic                  addr_ok;
    logic [DATA_W-1:0]     rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // Pin and low voltage inputs: three stages, change taken when last two agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_sync_reg <= 3'h7;
            pin_low_reg  <= 1'b0;
            lv_sync_reg  <= 3'h0;
            lv_reg       <= 1'b0;
        end
        else
        begin
            pin_sync_reg <= {pin_sync_reg[1:0], pin_reset_n};
            lv_sync_reg  <= {lv_sync_reg[1:0], low_voltage_det};
            if (pin_sync_reg[2] == pin_sync_reg[1])
            begin
                pin_low_reg <= ~pin_sync_reg[2];
            end
            if (lv_sync_reg[2] == lv_sync_reg[1])
            begin
                lv_reg <= lv_sync_reg[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset source qualification
    assign wdog_src = watchdog_timeout & options_reg[WDOG_EN_BIT];
    assign illegal_opcode_flag_src = illegal_opcode
                    | (stop_exec & ~options_reg[STOP_EN_BIT])
                    | (background_entry_instruction_exec & ~options_reg[BDM_EN_BIT]);
    assign any_src  = pin_low_reg | lv_reg | wdog_src | illegal_opcode_flag_src | clock_fault | dbg_force_reg;
    assign capture  = (state_reg == RSS_RUN) & any_src;

    // Next cause value for the reset being entered
    always_comb
    begin
        cause_next = '0;
        if (lv_reg)
        begin
            cause_next[POWER_ON_BIT]    = cause_reg[POWER_ON_BIT];
            cause_next[LOW_VOLTAGE_BIT] = 1'b1;
        end
        else
        begin
            // Power-on and low-voltage stay clear here; forced reset alone gives zero
            cause_next[PIN_RESET_BIT]   = pin_low_reg;
            cause_next[WATCHDOG_BIT]    = wdog_src;
            cause_next[ILLEGAL_OP_BIT]  = illegal_opcode_flag_src;
            cause_next[CLOCK_FAULT_BIT] = clock_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset cause register, power-on value under presetn
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cause_reg <= CAUSE_POR_VALUE;
        end
        else if (capture)
        begin
            cause_reg <= cause_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencer: holds system reset for a fixed count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= RSS_RUN;
            hold_cnt_reg <= '0;
            sys_reset    <= 1'b0;
        end
        else
        begin
            case (state_reg)
                RSS_RUN:
                begin
                    if (any_src)
                    begin
                        state_reg    <= RSS_HOLD;
                        hold_cnt_reg <= '0;
                        sys_reset    <= 1'b1;
                    end
                end
                RSS_HOLD:
                begin
                    if (hold_cnt_reg == HOLD_CNT_LAST)
                    begin
                        state_reg <= RSS_RUN;
                        sys_reset <= 1'b0;
                    end
                    else
                    begin
                        hold_cnt_reg <= hold_cnt_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB phase decode
    assign setup_phase = psel & ~penable;
    assign wr_fire     = psel & penable & pready & pwrite;
    assign addr_ok     = rss_hit(paddr, CAUSE_OFS) | rss_hit(paddr, OPTIONS_OFS) | rss_hit(paddr, DBG_FORCE_OFS)
                       | rss_hit(paddr, IRQ_STATUS_OFS) | rss_hit(paddr, IRQ_MASK_OFS) | rss_hit(paddr, IRQ_SRC_EN_OFS);

    // Read data selection
    always_comb
    begin
        rd_mux = '0;
        if (rss_hit(paddr, CAUSE_OFS))
        begin
            rd_mux[CAUSE_W-1:0] = cause_reg;
        end
        else if (rss_hit(paddr, OPTIONS_OFS))
        begin
            rd_mux[2:0] = options_reg;
        end
        else if (rss_hit(paddr, IRQ_STATUS_OFS))
        begin
            rd_mux[IRQ_W-1:0] = irq_status_reg;
        end
        else if (rss_hit(paddr, IRQ_MASK_OFS))
        begin
            rd_mux[IRQ_W-1:0] = irq_mask_reg;
        end
        else if (rss_hit(paddr, IRQ_SRC_EN_OFS))
        begin
            rd_mux[IRQ_W-1:0] = irq_src_en_reg;
        end
    end

    // Answer registered in setup, so access phase completes at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
        else if (setup_phase)
        begin
            pready  <= 1'b1;
            pslverr <= ~addr_ok;
            prdata  <= pwrite ? '0 : rd_mux;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog restart pulse on any write to the cause address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog_restart <= 1'b0;
        end
        else
        begin
            wdog_restart <= wr_fire & rss_hit(paddr, CAUSE_OFS);
        end
    end

    // Options: back to defaults whenever a system reset starts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            options_reg <= OPTIONS_RESET;
        end
        else if (capture)
        begin
            options_reg <= OPTIONS_RESET;
        end
        else if (wr_fire & rss_hit(paddr, OPTIONS_OFS))
        begin
            options_reg <= pwdata[2:0];
        end
    end

    // Debug forced reset request, self-clearing once the hold starts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dbg_force_reg <= 1'b0;
        end
        else if (capture)
        begin
            dbg_force_reg <= 1'b0;
        end
        else if (wr_fire & rss_hit(paddr, DBG_FORCE_OFS) & pwdata[DBG_FORCE_BIT])
        begin
            dbg_force_reg <= 1'b1;
        end
    end

    // Option outputs come straight from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog_enable <= OPTIONS_RESET[WDOG_EN_BIT];
            stop_enable <= OPTIONS_RESET[STOP_EN_BIT];
            bdm_enable  <= OPTIONS_RESET[BDM_EN_BIT];
        end
        else
        begin
            wdog_enable <= options_reg[WDOG_EN_BIT];
            stop_enable <= options_reg[STOP_EN_BIT];
            bdm_enable  <= options_reg[BDM_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events gated by source enable
    assign irq_raw = {irq_event, capture} & irq_src_en_reg;

    // Sticky status, write one to clear, new event beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status_reg <= '0;
        end
        else if (wr_fire & rss_hit(paddr, IRQ_STATUS_OFS))
        begin
            irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_W-1:0]) | irq_raw;
        end
        else
        begin
            irq_status_reg <= irq_status_reg | irq_raw;
        end
    end

    // Local enable and source enable registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask_reg   <= '0;
            irq_src_en_reg <= '0;
        end
        else
        begin
            if (wr_fire & rss_hit(paddr, IRQ_MASK_OFS))
            begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end
            if (wr_fire & rss_hit(paddr, IRQ_SRC_EN_OFS))
            begin
                irq_src_en_reg <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Level interrupt output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_status_reg & irq_mask_reg);
        end
    end

endmodule

// >>> testbench/rss_reset_status_asserts.sv
// Concurrent checks on the ports of the reset cause status block
`timescale 1ns/100ps

module rss_reset_status_asserts
    import rss_pkg::*;
#(
    parameter int IRQ_EXT = 4
)
(
    input wire logic                       pclk,
    input wire logic                       presetn,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [rss_pkg::ADDR_W-1:0] paddr,
    input wire logic [rss_pkg::DATA_W-1:0] pwdata,
    input wire logic [rss_pkg::DATA_W-1:0] prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       pin_reset_n,
    input wire logic                       low_voltage_det,
    input wire logic                       watchdog_timeout,
    input wire logic                       illegal_opcode,
    input wire logic                       stop_exec,
    input wire logic                       background_entry_instruction_exec,
    input wire logic                       clock_fault,
    input wire logic [IRQ_EXT-1:0]         irq_event,
    input wire logic                       sys_reset,
    input wire logic                       wdog_restart,
    input wire logic                       wdog_enable,
    input wire logic                       stop_enable,
    input wire logic                       bdm_enable,
    input wire logic                       irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////
    // Helper: length of the current system reset pulse
    logic [7:0] hold_cnt;
    logic       quiet;
    logic       cause_wr;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_cnt <= 8'h00;
        else
            hold_cnt <= sys_reset ? hold_cnt + 8'h01 : 8'h00;
    end
    // No other reset source busy
    assign quiet = pin_reset_n && !low_voltage_det && !illegal_opcode && !clock_fault
                 && !psel && !sys_reset && !background_entry_instruction_exec;
    assign cause_wr = psel && penable && pready && pwrite && (paddr == CAUSE_OFS);

    ////////////////////////////////////////////////////////////////////////
    a_ready_setup: assert property (psel && !penable |=> pready) else $error("pready missing after setup");
    a_ready_one: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_idle_data: assert property (!(psel && penable) |-> prdata == 32'h0) else $error("prdata not zero when idle");
    a_restart_cause: assert property (cause_wr |=> wdog_restart) else $error("no watchdog restart");
    a_restart_only: assert property (wdog_restart |-> $past(cause_wr)) else $error("stray watchdog restart");
    a_cause_bits: assert property (psel && penable && !pwrite && paddr == CAUSE_OFS
        |-> prdata[31:8] == 24'h0 && !prdata[3] && !prdata[0]) else $error("cause reads reserved bits");
    a_hold_len: assert property ($fell(sys_reset) |-> hold_cnt == 8'(RESET_HOLD_CYCLES))
        else $error("reset hold length wrong");
    a_illegal_rst: assert property (illegal_opcode && !sys_reset |=> sys_reset) else $error("illegal opcode no reset");
    a_wdog_block: assert property (quiet && !stop_exec && watchdog_timeout && !wdog_enable
        |=> !sys_reset) else $error("blocked watchdog reset");
    a_stop_legal: assert property (quiet && !watchdog_timeout && stop_exec && stop_enable
        |=> !sys_reset) else $error("legal stop caused reset");
    a_opts_dflt: assert property ($rose(sys_reset) |=> wdog_enable && !stop_enable && !bdm_enable)
        else $error("options not defaulted");
endmodule

bind rss_reset_status rss_reset_status_asserts #(.IRQ_EXT(IRQ_EXT)) rss_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_reset_n(pin_reset_n), .low_voltage_det(low_voltage_det),
    .watchdog_timeout(watchdog_timeout), .illegal_opcode(illegal_opcode), .stop_exec(stop_exec),
    .background_entry_instruction_exec(background_entry_instruction_exec), .clock_fault(clock_fault), .irq_event(irq_event), .sys_reset(sys_reset),
    .wdog_restart(wdog_restart), .wdog_enable(wdog_enable), .stop_enable(stop_enable),
    .bdm_enable(bdm_enable), .irq(irq));

// >>> testbench/rss_reset_status_tb.sv
// Self-checking bench for the reset cause status block
`timescale 1ns/100ps

module rss_reset_status_tb;
    import rss_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, seed = 32'h7d144c8c;
    logic        pready, pslverr, sys_reset, wdog_restart, wdog_enable, stop_enable, bdm_enable, irq;
    logic        pin_reset_n = 1, low_voltage_det = 0, watchdog_timeout = 0, illegal_opcode = 0;
    logic        stop_exec = 0, background_entry_instruction_exec = 0, clock_fault = 0;
    logic [3:0]  irq_event = 0, ev;
    logic [1:0]  seen = 0;
    logic [32:0] exp_q[$];
    int          failures = 0, check_count = 0;

    rss_reset_status rss_reset_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_reset_n(pin_reset_n), .low_voltage_det(low_voltage_det), .watchdog_timeout(watchdog_timeout),
        .illegal_opcode(illegal_opcode), .stop_exec(stop_exec), .background_entry_instruction_exec(background_entry_instruction_exec),
        .clock_fault(clock_fault), .irq_event(irq_event), .sys_reset(sys_reset), .wdog_restart(wdog_restart),
        .wdog_enable(wdog_enable), .stop_enable(stop_enable), .bdm_enable(bdm_enable), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // Clock and watchdog
    initial
    begin
        forever #25 pclk = ~pclk;
    end
    initial
    begin
        #(5000 * 50);
        failures++;
        wrap_up;
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk_rd(input logic [32:0] e);
        check_count++;
        if ({pslverr, prdata} !== e)
        begin
            failures++;
            $display("BAD read exp %h got %h", e, {pslverr, prdata});
        end
    endtask
    task automatic chk_sig(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // APB transfer; reads note their expectation first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        if (!w)
            exp_q.push_back(e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    // Read result monitor and sticky pulse catchers
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk_rd(exp_q.pop_front());
        if (sys_reset === 1'b1)
            seen[0] <= 1;
        if (wdog_restart === 1'b1)
            seen[1] <= 1;
    end
    // Set options, fire one source, check reset and captured cause
    task automatic trig(input int s, input logic [2:0] o, input logic r, input logic [7:0] c);
        apb(1, OPTIONS_OFS, 32'(o), 0);
        cyc(1);
        chk_sig("options", 8'(o), {5'h0, bdm_enable, stop_enable, wdog_enable});
        seen <= 0;
        case (s)
            0: watchdog_timeout <= 1;
            1: illegal_opcode <= 1;
            2: stop_exec <= 1;
            3: background_entry_instruction_exec <= 1;
            4: clock_fault <= 1;
            5: low_voltage_det <= 1;
            6: pin_reset_n <= 0;
            default: apb(1, DBG_FORCE_OFS, 32'h1, 0);
        endcase
        cyc(6);
        {watchdog_timeout, illegal_opcode, stop_exec, background_entry_instruction_exec, clock_fault, low_voltage_det} <= 0;
        pin_reset_n <= 1;
        cyc(45);
        chk_sig("sys_reset", 8'(r), 8'(seen[0]));
        apb(0, CAUSE_OFS, 0, {25'h0, c});
    endtask
    task automatic wrap_up;
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, CAUSE_OFS, 0, 33'h82);
        apb(0, OPTIONS_OFS, 0, 33'h1);
        apb(0, DBG_FORCE_OFS, 0, 33'h0);
        apb(0, 8'h20, 0, {1'b1, 32'h0});
        seed = lfsr(seed);
        apb(1, CAUSE_OFS, seed, 0);
        cyc(1);
        chk_sig("restart", 8'h1, 8'(seen[1]));
        apb(0, CAUSE_OFS, 0, 33'h82);
        // Interrupt gating
        seed = lfsr(seed);
        ev = seed[3:0] | 4'h1;
        apb(1, IRQ_SRC_EN_OFS, 32'h1e, 0);
        apb(1, IRQ_MASK_OFS, 32'h0, 0);
        irq_event <= ev;
        cyc(1);
        irq_event <= 0;
        cyc(2);
        apb(0, IRQ_STATUS_OFS, 0, {28'h0, ev, 1'b0});
        chk_sig("irq", 8'h0, 8'(irq));
        apb(1, IRQ_MASK_OFS, 32'h1f, 0);
        cyc(2);
        chk_sig("irq", 8'h1, 8'(irq));
        apb(1, IRQ_STATUS_OFS, {27'h0, ev, 1'b0}, 0);
        apb(1, IRQ_SRC_EN_OFS, 32'h1, 0);
        irq_event <= 4'hf;
        cyc(1);
        irq_event <= 0;
        cyc(2);
        chk_sig("irq", 8'h0, 8'(irq));
        apb(0, IRQ_STATUS_OFS, 0, 33'h0);
        // Reset sources
        trig(0, 3'h1, 1, 8'h20);
        trig(5, 3'h1, 1, 8'h02);
        trig(1, 3'h1, 1, 8'h10);
        trig(2, 3'h1, 1, 8'h10);
        trig(3, 3'h1, 1, 8'h10);
        trig(4, 3'h1, 1, 8'h04);
        trig(6, 3'h1, 1, 8'h40);
        trig(0, 3'h0, 0, 8'h40);
        trig(2, 3'h2, 0, 8'h40);
        trig(3, 3'h4, 0, 8'h40);
        trig(7, 3'h1, 1, 8'h00);
        apb(0, IRQ_STATUS_OFS, 0, 33'h1);
        chk_sig("irq", 8'h1, 8'(irq));
        // Power-on again, then low voltage keeps the power-on flag
        presetn <= 0;
        cyc(2);
        presetn <= 1;
        cyc(1);
        trig(5, 3'h1, 1, 8'h82);
        wrap_up;
    end
endmodule
